// File: dv/cpu_request_model.sv
// Purpose: CPU side model issuing code fetches and data accesses.
// Assumes: Each bench command becomes a request one edge later.
// Notes: Idle address lines are inverted every cycle, so a decoder that
//        looks at a stale address cannot pass by luck.
`timescale 1ns/100ps
`default_nettype none
module cpu_request_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Commands from the bench
    input wire logic cmd_fetch,
    input wire logic cmd_data,
    input wire logic cmd_write,
    input wire logic cmd_word,
    input wire logic [23:0] cmd_fetch_addr,
    input wire logic [23:0] cmd_data_addr,
    // Requests towards the decoder
    output logic fetch_req,
    output logic [23:0] fetch_addr,
    output logic data_req,
    output logic data_write,
    output logic data_word,
    output logic [23:0] data_addr
);
    initial begin
        fetch_req = 1'b0;
        data_req = 1'b0;
        data_write = 1'b0;
        data_word = 1'b0;
        fetch_addr = 24'h000000;
        data_addr = 24'h000000;
    end

    // Fetch and data sides issue independently, often in one cycle
    always @(posedge ref_clk) begin
        fetch_req <= cmd_fetch & ~rst;
        data_req <= cmd_data & ~rst;
        data_write <= cmd_data ? cmd_write : ~data_write;
        data_word <= cmd_data ? cmd_word : ~data_word;
        fetch_addr <= cmd_fetch ? cmd_fetch_addr : ~fetch_addr;
        data_addr <= cmd_data ? cmd_data_addr : ~data_addr;
    end
endmodule : cpu_request_model
`default_nettype wire

// File: dv/memory_map_address_decoder_tb_top.sv
// Purpose: Self-checking bench for the address decoder.
// Assumes: Every answer follows its request edge by one cycle.
// Notes: Addresses come from a region table plus a random offset.
`timescale 1ns/100ps
`default_nettype none
module memory_map_address_decoder_tb_top;
    logic ref_clk, rst, ext_bus_present, read_protect, password_valid;
    logic lock_request, fetch_req, data_req, data_write, data_word;
    logic cmd_fetch, cmd_data, cmd_write, cmd_word, exp_unl = 1'b0;
    logic [14:0] program_sram_prot_limit;
    logic [15:0] password;
    logic [23:0] fetch_addr, data_addr, cmd_fetch_addr, cmd_data_addr;
    logic fetch_ack, fetch_trap, data_ack, data_bit_addressable, data_trap;
    logic data_write_blocked, data_via_system_bus, strict_order;
    logic flash_unlocked, fl, ctl_f, ctl_d;
    logic [10:0] fetch_target, data_target, ft, dt;
    logic [1:0] fetch_flash_module, data_flash_module, data_page, data_lanes;
    logic [31:0] lfsr;
    int num_errors, checks_done;
    // Request taken at the last edge, with the settings of that edge
    logic m_f = 1'b0, m_d = 1'b0, m_w, m_wd, m_ext, m_rp, m_unl;
    logic [14:0] m_lim;
    logic [23:0] m_fa, m_da;
    logic [23:0] bases [19] = '{24'h000000, 24'h008000, 24'h00a000,
        24'h00e000, 24'h00f000, 24'h00f200, 24'h00f600, 24'h00fd00,
        24'h00fe00, 24'h200000, 24'h400000, 24'hc00000, 24'hc40000,
        24'hcc0000, 24'hcd0000, 24'he00000, 24'he08000, 24'hf00000,
        24'hffff00};
    int holes_at [3] = '{1, 5, 14};

    cpu_request_model cpu_request_model_i (.ref_clk(ref_clk), .rst(rst),
        .cmd_fetch(cmd_fetch), .cmd_data(cmd_data), .cmd_write(cmd_write),
        .cmd_word(cmd_word), .cmd_fetch_addr(cmd_fetch_addr),
        .cmd_data_addr(cmd_data_addr), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .data_req(data_req),
        .data_write(data_write), .data_word(data_word),
        .data_addr(data_addr));

    memory_map_address_decoder memory_map_address_decoder_i (.*);

    function automatic logic [31:0] step(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : step

    function automatic logic [10:0] exp_tgt(input logic [23:0] a,
                                            input logic ext);
        logic [10:0] hole;
        hole = ext ? memory_map_pkg::TGT_EXT : memory_map_pkg::TGT_NONE;
        if (a < 24'h008000) return memory_map_pkg::TGT_EXT;
        if (a < 24'h00a000) return hole;
        if (a < 24'h00e000) return memory_map_pkg::TGT_DATA_SRAM;
        if (a < 24'h00f000) return memory_map_pkg::TGT_XSFR;
        if (a < 24'h00f200) return memory_map_pkg::TGT_EXTENDED_REGISTER_AREA;
        if (a < 24'h00f600) return hole;
        if (a < 24'h00fe00) return memory_map_pkg::TGT_DUAL_PORT_RAM;
        if (a < 24'h010000) return memory_map_pkg::TGT_SFR;
        if (a < 24'hc00000) return memory_map_pkg::TGT_EXT;
        if (a < 24'hcd0000) return memory_map_pkg::TGT_FLASH;
        if (a < 24'he00000) return hole;
        if (a < 24'hf00000) return memory_map_pkg::TGT_PROGRAM_SRAM;
        if (a < 24'hffff00) return memory_map_pkg::TGT_TRAP;
        return memory_map_pkg::TGT_IMB;
    endfunction : exp_tgt

    task automatic check(input string what, input logic [23:0] seen,
                         input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    // Random mixed traffic; hole mode aims data accesses at gaps only
    task automatic traffic(input int n, input bit holes);
        logic [23:0] a;
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            lfsr = step(lfsr);
            a = holes ? bases[holes_at[lfsr[17:16] % 3]]
                      : bases[lfsr[20:16] % 19];
            a = a + {16'h0000, lfsr[15:8]};
            a[0] = a[0] & ~lfsr[7];
            cmd_fetch <= lfsr[3] & ~holes;
            cmd_data <= lfsr[4] | lfsr[5] | holes;
            // Write and size flags are random; word accesses get an even address
            cmd_write <= lfsr[6];
            cmd_word <= lfsr[7];
            cmd_data_addr <= a;
            cmd_fetch_addr <= bases[10 + lfsr[27:24] % 9] + 24'(lfsr[15:8]);
        end
        @(posedge ref_clk);
        cmd_fetch <= 1'b0;
        cmd_data <= 1'b0;
        repeat (3) @(posedge ref_clk);
        $display("test traffic holes=%0d done", holes);
    endtask : traffic

    task automatic flash_read(input logic [23:0] a);
        @(posedge ref_clk);
        cmd_fetch <= 1'b1;
        cmd_data <= 1'b1;
        cmd_write <= 1'b0;
        cmd_word <= 1'b1;
        cmd_fetch_addr <= a;
        cmd_data_addr <= a;
        @(posedge ref_clk);
        cmd_fetch <= 1'b0;
        cmd_data <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : flash_read

    task automatic unlock_try(input logic [15:0] pw, input logic lock);
        @(posedge ref_clk);
        password <= pw;
        password_valid <= ~lock;
        lock_request <= lock;
        @(posedge ref_clk);
        password_valid <= 1'b0;
        lock_request <= 1'b0;
        flash_read(24'hc40010);
    endtask : unlock_try

    always @(posedge ref_clk) begin
        {m_f, m_d, m_w, m_wd} <= {fetch_req, data_req, data_write, data_word};
        {m_fa, m_da} <= {fetch_addr, data_addr};
        {m_ext, m_rp, m_unl} <= {ext_bus_present, read_protect, exp_unl};
        m_lim <= program_sram_prot_limit;
        if (rst) begin
            exp_unl <= 1'b0;
        end else if (password_valid
                     && password === memory_map_pkg::PASSWORD_RESET) begin
            exp_unl <= 1'b1;
        end else if (lock_request) begin
            exp_unl <= 1'b0;
        end
    end

    always @(negedge ref_clk) begin
        ft = exp_tgt(m_fa, m_ext);
        dt = exp_tgt(m_da, m_ext);
        fl = dt == memory_map_pkg::TGT_FLASH;
        // Control sector, locked flash and flash stores all trap
        ctl_f = ft == memory_map_pkg::TGT_FLASH &&
            (m_fa inside {[24'hc0f000:24'hc0ffff]} || m_rp && !m_unl);
        ctl_d = fl &&
            (m_da inside {[24'hc0f000:24'hc0ffff]} || m_rp && !m_unl || m_w);
        check("fetch_ack", 24'(fetch_ack), 24'(m_f));
        check("data_ack", 24'(data_ack), 24'(m_d));
        check("flash_unlocked", 24'(flash_unlocked), 24'(exp_unl));
        if (m_f) begin
            check("fetch_target", 24'(fetch_target), 24'(ft));
            check("fetch_trap", 24'(fetch_trap), 24'(ctl_f
                || ft == memory_map_pkg::TGT_NONE
                || ft == memory_map_pkg::TGT_TRAP));
            if (ft == memory_map_pkg::TGT_FLASH) begin
                check("fetch_module", 24'(fetch_flash_module),
                      24'(m_fa[19:18]));
            end
        end
        if (m_d) begin
            check("data_target", 24'(data_target), 24'(dt));
            check("data_page", 24'(data_page), 24'(m_da[15:14]));
            check("data_lanes", 24'(data_lanes), m_wd ? 24'h3
                  : (m_da[0] ? 24'h2 : 24'h1));
            // Any DUAL_PORT_RAM word may hold a register bank, so all of it counts
            check("bit_addr", 24'(data_bit_addressable),
                  24'(dt inside {memory_map_pkg::TGT_EXTENDED_REGISTER_AREA,
                  memory_map_pkg::TGT_SFR, memory_map_pkg::TGT_DUAL_PORT_RAM}));
            check("data_trap", 24'(data_trap), 24'(ctl_d
                || dt == memory_map_pkg::TGT_NONE
                || dt == memory_map_pkg::TGT_TRAP));
            check("write_blocked", 24'(data_write_blocked), 24'(m_w
                && dt == memory_map_pkg::TGT_PROGRAM_SRAM && m_da < 24'he80000
                && m_da[14:0] < m_lim));
            check("strict_order", 24'(strict_order),
                  24'(m_da inside {[24'h200000:24'h3fffff]}));
            if (dt != memory_map_pkg::TGT_IMB) begin
                check("system_bus", 24'(data_via_system_bus), 24'(fl
                    || dt == memory_map_pkg::TGT_PROGRAM_SRAM
                    || dt == memory_map_pkg::TGT_EXT));
            end
            if (fl) begin
                check("data_module", 24'(data_flash_module),
                      24'(m_da[19:18]));
            end
        end
    end

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Hang guard
    initial begin
        #300000;
        num_errors++;
        finish_test();
    end

    initial begin
        {rst, ext_bus_present} = 2'b11;
        {read_protect, password_valid, lock_request} = 3'b000;
        {cmd_fetch, cmd_data, cmd_write, cmd_word} = 4'h0;
        {cmd_fetch_addr, cmd_data_addr} = 48'h000000000000;
        program_sram_prot_limit = 15'h0080;
        password = 16'h0000;
        lfsr = 32'd89098;
        num_errors = 0;
        checks_done = 0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        check("reset_target", 24'(data_target),
              24'(memory_map_pkg::TGT_NONE));
        $display("test reset done");
        traffic(300, 1'b0);
        ext_bus_present <= 1'b0;
        traffic(60, 1'b1);
        ext_bus_present <= 1'b1;
        traffic(30, 1'b1);
        flash_read(24'hc0f010);
        @(posedge ref_clk);
        read_protect <= 1'b1;
        flash_read(24'hc40010);
        unlock_try(16'h1234, 1'b0);
        unlock_try(16'h0000, 1'b0);
        unlock_try(16'h0000, 1'b1);
        $display("test read protection done");
        finish_test();
    end
endmodule : memory_map_address_decoder_tb_top
`default_nettype wire

// File: logic/memory_map_address_decoder.sv
// Purpose: Routes CPU fetches and data accesses to on-chip targets.
// Assumes: Requests come from logic on ref_clk; one fetch and one data
//          access may be presented in the same cycle.
// Notes: Decisions are registered; each answer follows its request by
//        one cycle.
// Overview of operation
// - One linear address space decodes code, data, registers and ports.
// - 16 Mbytes as 256 segments of 64 Kbytes; top byte is segment.
// - Each segment holds four 16-Kbyte data pages.
// - Every location accepts byte and word accesses.
// - Data memories and both register areas decode in segment 0.
// - Reserved holes go to the external bus when it exists; F00000 to FFFEFF always traps.
// - Flash control sector C0F000 to C0FFFF is not user memory.
// - External IO accesses disable pipeline speed optimizations.
// - All code fetches pass through the program fetch manager.
// - All data transfers pass through the data transfer manager.
// - Manager link carries transfers both ways at the same time.
// - A programmable low section of program SRAM is write-protected.
// - Data SRAM has its own dedicated interface.
// - Sixteen word registers, also reachable as byte halves.
// - All DUAL_PORT_RAM bytes and register locations are bit addressable.
// - Both register areas span 512 bytes of word-wide registers.
// - Flash is one 64K module plus 256K modules of 4K sectors.
// - Per-sector write protect and erase; programming in 128-byte blocks.
// - Read-protected flash unlocks temporarily after correct password.
// - Flash reads fetch 128 bits and pass through error correction.
// - Accesses to different flash modules proceed in parallel.
`timescale 1ns/100ps
`default_nettype none
module memory_map_address_decoder (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Configuration
    input wire logic ext_bus_present,
    input wire logic [14:0] program_sram_prot_limit,
    input wire logic read_protect,
    input wire logic [15:0] password,
    input wire logic password_valid,
    input wire logic lock_request,
    // Code fetch request
    input wire logic fetch_req,
    input wire logic [23:0] fetch_addr,
    // Data request
    input wire logic data_req,
    input wire logic data_write,
    input wire logic data_word,
    input wire logic [23:0] data_addr,
    // Fetch answer
    output logic fetch_ack,
    output logic [10:0] fetch_target,
    output logic [1:0] fetch_flash_module,
    output logic fetch_trap,
    // Data answer
    output logic data_ack,
    output logic [10:0] data_target,
    output logic [1:0] data_flash_module,
    output logic [1:0] data_page,
    output logic [1:0] data_lanes,
    output logic data_bit_addressable,
    output logic data_trap,
    output logic data_write_blocked,
    output logic data_via_system_bus,
    output logic strict_order,
    output logic flash_unlocked
);
    function automatic memory_map_pkg::target_e decode(
        input logic [23:0] a, input logic ext);
        memory_map_pkg::target_e t;
        t = memory_map_pkg::TGT_EXT;
        if (a[23:16] == memory_map_pkg::SYS_SEGMENT) begin
            if (a <= memory_map_pkg::EXT_LOW_END)
                t = memory_map_pkg::TGT_EXT;
            else if (a <= memory_map_pkg::DATA_SRAM_GAP_END)
                t = memory_map_pkg::TGT_NONE;
            else if (a <= memory_map_pkg::DATA_SRAM_END)
                t = memory_map_pkg::TGT_DATA_SRAM;
            else if (a <= memory_map_pkg::XSFR_END)
                t = memory_map_pkg::TGT_XSFR;
            else if (a <= memory_map_pkg::EXTENDED_REGISTER_AREA_END)
                t = memory_map_pkg::TGT_EXTENDED_REGISTER_AREA;
            else if (a <= memory_map_pkg::DUAL_PORT_RAM_GAP_END)
                t = memory_map_pkg::TGT_NONE;
            else if (a <= memory_map_pkg::DUAL_PORT_RAM_END)
                t = memory_map_pkg::TGT_DUAL_PORT_RAM;
            else t = memory_map_pkg::TGT_SFR;
        end else if (a < memory_map_pkg::FLASH_START) begin
            t = memory_map_pkg::TGT_EXT;
        end else if (a <= memory_map_pkg::FLASH_END) begin
            t = memory_map_pkg::TGT_FLASH;
        end else if (a <= memory_map_pkg::FLASH_RSV_END) begin
            t = memory_map_pkg::TGT_NONE;
        end else if (a <= memory_map_pkg::PROGRAM_SRAM_END) begin
            t = memory_map_pkg::TGT_PROGRAM_SRAM;
        end else if (a <= memory_map_pkg::PROGRAM_SRAM_MIRROR_END) begin
            t = memory_map_pkg::TGT_PROGRAM_SRAM;
        end else if (a <= memory_map_pkg::EPSRAM_MIRROR_END) begin
            t = memory_map_pkg::TGT_PROGRAM_SRAM;
        end else if (a <= memory_map_pkg::TRAP_END) begin
            t = memory_map_pkg::TGT_TRAP;
        end else begin
            t = memory_map_pkg::TGT_IMB;
        end
        // Shaded holes fall to the external bus only when it is fitted
        if (t == memory_map_pkg::TGT_NONE && ext)
            t = memory_map_pkg::TGT_EXT;
        return t;
    endfunction : decode

    function automatic logic [1:0] flash_module(input logic [23:0] a);
        // Module bits sit above the 128-bit line offset: a line never splits
        return a[19:18];
    endfunction : flash_module

    function automatic logic flash_reserved(input logic [23:0] a);
        return a >= memory_map_pkg::FLASH_CTRL_START &&
            a <= memory_map_pkg::FLASH_CTRL_END;
    endfunction : flash_reserved

    typedef enum logic [1:0] {
        LOCKED = 2'b01,
        OPEN = 2'b10
    } unlock_e;

    memory_map_pkg::target_e f_t;
    memory_map_pkg::target_e d_t;
    unlock_e unlock_state;
    unlock_e next_unlock_state;
    logic f_block;
    logic d_block;
    logic d_wp;
    logic next_fetch_ack;
    logic [10:0] next_fetch_target;
    logic [1:0] next_fetch_flash_module;
    logic next_fetch_trap;
    logic next_data_ack;
    logic [10:0] next_data_target;
    logic [1:0] next_data_flash_module;
    logic [1:0] next_data_page;
    logic [1:0] next_data_lanes;
    logic next_data_bit_addressable;
    logic next_data_trap;
    logic next_data_write_blocked;
    logic next_data_via_system_bus;
    logic next_strict_order;

    // Password unlock holds until software locks again or reset
    always_comb begin
        next_unlock_state = unlock_state;
        case (unlock_state)
            LOCKED: begin
                if (password_valid &&
                    password == memory_map_pkg::PASSWORD_RESET)
                    next_unlock_state = OPEN;
            end
            OPEN: begin
                if (lock_request)
                    next_unlock_state = LOCKED;
            end
            default: next_unlock_state = LOCKED;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst)
            unlock_state <= LOCKED;
        else
            unlock_state <= next_unlock_state;
    end

    always_comb begin
        f_t = decode(fetch_addr, ext_bus_present);
        d_t = decode(data_addr, ext_bus_present);
        f_block = f_t == memory_map_pkg::TGT_FLASH &&
            (flash_reserved(fetch_addr) ||
             (read_protect && unlock_state != OPEN));
        // Flash changes only through its own command sequence, never a store
        d_block = d_t == memory_map_pkg::TGT_FLASH &&
            (flash_reserved(data_addr) ||
             (read_protect && unlock_state != OPEN) || data_write);
        // Program SRAM and its mirror alias the same cells, so the
        // protected section is guarded through either window
        d_wp = d_t == memory_map_pkg::TGT_PROGRAM_SRAM && data_write &&
            data_addr[23:19] == memory_map_pkg::PROGRAM_SRAM_START[23:19] &&
            data_addr[14:0] < program_sram_prot_limit;
        next_fetch_ack = fetch_req;
        next_fetch_target = fetch_req ? f_t : memory_map_pkg::TGT_NONE;
        next_fetch_flash_module = flash_module(fetch_addr);
        next_fetch_trap = fetch_req && (f_t == memory_map_pkg::TGT_TRAP ||
            f_t == memory_map_pkg::TGT_NONE || f_block);
        next_data_ack = data_req;
        next_data_target = data_req ? d_t : memory_map_pkg::TGT_NONE;
        next_data_flash_module = flash_module(data_addr);
        next_data_page = data_addr[15:memory_map_pkg::PAGE_W];
        // Odd word addresses still allowed: words use both lanes, bytes follow the low bit
        next_data_lanes = data_word ? 2'b11 :
            (data_addr[0] ? 2'b10 : 2'b01);
        next_data_bit_addressable = data_req &&
            ((data_addr >= memory_map_pkg::DUAL_PORT_RAM_BIT_START &&
              data_addr <= memory_map_pkg::DUAL_PORT_RAM_END) ||
             d_t == memory_map_pkg::TGT_DUAL_PORT_RAM ||
             d_t == memory_map_pkg::TGT_SFR ||
             d_t == memory_map_pkg::TGT_EXTENDED_REGISTER_AREA);
        next_data_trap = data_req && (d_t == memory_map_pkg::TGT_TRAP ||
            d_t == memory_map_pkg::TGT_NONE || d_block);
        next_data_write_blocked = data_req && d_wp;
        // Flash and program SRAM live on the fetch side of the link
        next_data_via_system_bus = data_req &&
            (d_t == memory_map_pkg::TGT_FLASH ||
             d_t == memory_map_pkg::TGT_PROGRAM_SRAM ||
             d_t == memory_map_pkg::TGT_EXT);
        next_strict_order = data_req &&
            data_addr >= memory_map_pkg::EXT_IO_START &&
            data_addr <= memory_map_pkg::EXT_IO_END;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fetch_ack <= 1'b0;
            fetch_target <= memory_map_pkg::TGT_NONE;
            fetch_flash_module <= 2'b00;
            fetch_trap <= 1'b0;
            data_ack <= 1'b0;
            data_target <= memory_map_pkg::TGT_NONE;
            data_flash_module <= 2'b00;
            data_page <= 2'b00;
            data_lanes <= 2'b00;
            data_bit_addressable <= 1'b0;
            data_trap <= 1'b0;
            data_write_blocked <= 1'b0;
            data_via_system_bus <= 1'b0;
            strict_order <= 1'b0;
            flash_unlocked <= 1'b0;
        end else begin
            fetch_ack <= next_fetch_ack;
            fetch_target <= next_fetch_target;
            fetch_flash_module <= next_fetch_flash_module;
            fetch_trap <= next_fetch_trap;
            data_ack <= next_data_ack;
            data_target <= next_data_target;
            data_flash_module <= next_data_flash_module;
            data_page <= next_data_page;
            data_lanes <= next_data_lanes;
            data_bit_addressable <= next_data_bit_addressable;
            data_trap <= next_data_trap;
            data_write_blocked <= next_data_write_blocked;
            data_via_system_bus <= next_data_via_system_bus;
            strict_order <= next_strict_order;
            flash_unlocked <= next_unlock_state == OPEN;
        end
    end

    AST_TRAP_TOP: assert property (
        @(posedge ref_clk) disable iff (rst)
        data_req && data_addr >= memory_map_pkg::TRAP_START &&
        data_addr <= memory_map_pkg::TRAP_END |=> data_trap)
        else $error("top reserved range did not trap");
    AST_CTRL_SECTOR: assert property (
        @(posedge ref_clk) disable iff (rst)
        fetch_req && flash_reserved(fetch_addr) |=> fetch_trap)
        else $error("flash control sector fetched");
    AST_EXT_IO: assert property (
        @(posedge ref_clk) disable iff (rst)
        data_req && data_addr[23:21] == 3'b001 |=> strict_order)
        else $error("external IO without strict order");
    AST_PROGRAM_SRAM_WP: assert property (
        @(posedge ref_clk) disable iff (rst)
        data_req && data_write && data_addr[23:15] == 9'h1c0 &&
        data_addr[14:0] < program_sram_prot_limit |=> data_write_blocked)
        else $error("protected program SRAM write passed");
    AST_SEG0: assert property (
        @(posedge ref_clk) disable iff (rst)
        data_req && data_addr[23:16] != 8'h00 |=>
        data_target != memory_map_pkg::TGT_DATA_SRAM &&
        data_target != memory_map_pkg::TGT_SFR)
        else $error("system target outside segment 0");
    AST_LANES: assert property (
        @(posedge ref_clk) disable iff (rst)
        data_req && !data_word |=> $countones(data_lanes) == 1)
        else $error("byte access used two lanes");
    AST_PAGE: assert property (
        @(posedge ref_clk) disable iff (rst)
        data_req |=> data_page == $past(data_addr[15:14]))
        else $error("data page wrong");
    AST_LOCKED: assert property (
        @(posedge ref_clk) disable iff (rst)
        fetch_req && read_protect && !flash_unlocked && !password_valid &&
        fetch_addr >= memory_map_pkg::FLASH_START &&
        fetch_addr <= memory_map_pkg::FLASH_END |=> fetch_trap)
        else $error("locked flash fetched");
    AST_SHADED_EXT: assert property (
        @(posedge ref_clk) disable iff (rst)
        data_req && ext_bus_present && data_addr >= 24'h008000 &&
        data_addr <= 24'h009fff |=>
        data_target == memory_map_pkg::TGT_EXT)
        else $error("shaded range not sent external");
    AST_FLASH_WRITE: assert property (
        @(posedge ref_clk) disable iff (rst)
        data_req && data_write &&
        data_addr >= memory_map_pkg::FLASH_START &&
        data_addr <= memory_map_pkg::FLASH_END |=> data_trap)
        else $error("store into flash not trapped");
endmodule : memory_map_address_decoder
`default_nettype wire

// File: logic/memory_map_pkg.sv
// Purpose: Constants for the linear address space decoder.
// Assumes: 24-bit byte address, 16-bit data path.
// Notes: Region bounds are inclusive start and end addresses.
package memory_map_pkg;
    localparam int ADDR_W = 24;
    localparam int PAGE_W = 14;
    localparam logic [7:0] SYS_SEGMENT = 8'h00;
    localparam logic [23:0] EXT_LOW_END = 24'h007fff;
    localparam logic [23:0] DATA_SRAM_GAP_END = 24'h009fff;
    localparam logic [23:0] DATA_SRAM_START = 24'h00a000;
    localparam logic [23:0] DATA_SRAM_END = 24'h00dfff;
    localparam logic [23:0] XSFR_END = 24'h00efff;
    localparam logic [23:0] EXTENDED_REGISTER_AREA_START = 24'h00f000;
    localparam logic [23:0] EXTENDED_REGISTER_AREA_END = 24'h00f1ff;
    localparam logic [23:0] DUAL_PORT_RAM_GAP_END = 24'h00f5ff;
    localparam logic [23:0] DUAL_PORT_RAM_START = 24'h00f600;
    localparam logic [23:0] DUAL_PORT_RAM_END = 24'h00fdff;
    localparam logic [23:0] DUAL_PORT_RAM_BIT_START = 24'h00fd00;
    localparam logic [23:0] SFR_START = 24'h00fe00;
    localparam logic [23:0] EXT_IO_START = 24'h200000;
    localparam logic [23:0] EXT_IO_END = 24'h3fffff;
    localparam logic [23:0] FLASH_START = 24'hc00000;
    localparam logic [23:0] FLASH_CTRL_START = 24'hc0f000;
    localparam logic [23:0] FLASH_CTRL_END = 24'hc0ffff;
    localparam logic [23:0] FLASH_END = 24'hccffff;
    localparam logic [23:0] FLASH_RSV_END = 24'hdfffff;
    localparam logic [23:0] PROGRAM_SRAM_START = 24'he00000;
    localparam logic [23:0] PROGRAM_SRAM_END = 24'he07fff;
    localparam logic [23:0] PROGRAM_SRAM_MIRROR_END = 24'he7ffff;
    localparam logic [23:0] EPSRAM_START = 24'he80000;
    localparam logic [23:0] EPSRAM_END = 24'he87fff;
    localparam logic [23:0] EPSRAM_MIRROR_END = 24'hefffff;
    localparam logic [23:0] TRAP_START = 24'hf00000;
    localparam logic [23:0] TRAP_END = 24'hfffeff;
    localparam int FLASH_MODULES = 4;
    localparam int FLASH_SECTOR_W = 12;
    localparam int FLASH_BLOCK_W = 7;
    localparam int FLASH_LINE_W = 4;
    localparam int PROGRAM_SRAM_IDX_W = 15;
    localparam logic [14:0] PROGRAM_SRAM_PROT_RESET = 15'h0000;
    localparam logic [15:0] PASSWORD_RESET = 16'h0000;

    typedef enum logic [10:0] {
        TGT_NONE = 11'h001,
        TGT_DATA_SRAM = 11'h002,
        TGT_DUAL_PORT_RAM = 11'h004,
        TGT_SFR = 11'h008,
        TGT_EXTENDED_REGISTER_AREA = 11'h010,
        TGT_XSFR = 11'h020,
        TGT_FLASH = 11'h040,
        TGT_PROGRAM_SRAM = 11'h080,
        TGT_EXT = 11'h100,
        TGT_TRAP = 11'h200,
        TGT_IMB = 11'h400
    } target_e;
endpackage : memory_map_pkg
